// [include/boot_sel_map.svh]
// constants for the boot mode selector: offsets, fields, codes, timing
`ifndef BOOT_SEL_MAP_SVH
`define BOOT_SEL_MAP_SVH

// register byte offsets
`define OFS_EMU_WORD 32'h0000_0000
`define OFS_STATUS 32'h0000_0004
`define OFS_ZONE_ONE 32'h0000_0008
`define OFS_ZONE_TWO 32'h0000_000c
`define ADDR_WORD_MASK 32'hffff_fffc

// boot control word layout
`define KEY_LSB 0
`define KEY_MSB 7
`define KEY_VALUE 8'h5a
`define CODE_LSB 8
`define CODE_MSB 10
`define OPTION_BIT 12

// status register layout
`define ST_DONE_BIT 0
`define ST_EMU_BIT 1
`define ST_OPT_BIT 2
`define ST_MODE_LSB 4
`define ST_MODE_MSB 6
`define ST_SRC_LSB 8
`define ST_SRC_MSB 9
`define ST_XTAL_BIT 10

// reset values
`define EMU_WORD_RESET 32'h0000_0000

// strap settle time: sampled pins agree for this many cycles
`define SETTLE_CYCLES 4'h4

// axi responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// [include/boot_sel_pkg.sv]
// types shared by the boot mode selector
package boot_sel_pkg;

  // boot targets, codes match the control word code field
  typedef enum logic [2:0] {
    MODE_PARALLEL = 3'h0,
    MODE_SERIAL = 3'h1,
    MODE_WAIT = 3'h2,
    MODE_FLASH = 3'h3,
    MODE_SPI = 3'h4,
    MODE_I2C = 3'h5,
    MODE_CAN = 3'h6,
    MODE_USB = 3'h7
  } boot_mode_t;

  // where the final decision came from
  typedef enum logic [1:0] {
    SRC_STRAP = 2'h0,
    SRC_EMU = 2'h1,
    SRC_ZONE_ONE = 2'h2,
    SRC_ZONE_TWO = 2'h3
  } boot_src_t;

  // selection sequence, gray along settle-strap-zone1-zone2-done
  typedef enum logic [2:0] {
    ST_SETTLE = 3'b000,
    ST_STRAP = 3'b001,
    ST_ZONE_ONE = 3'b011,
    ST_ZONE_TWO = 3'b010,
    ST_DONE = 3'b110,
    ST_EMU = 3'b100
  } sel_state_t;

  // one decision
  typedef struct packed {
    boot_mode_t mode;
    logic pin_option;
    boot_src_t source;
  } boot_sel_t;

endpackage

// [rtl/boot_mode_selector.sv]
// boot mode selection with an axi4-lite register port
`timescale 1ns/1ps
`default_nettype none
`include "boot_sel_map.svh"

module boot_mode_selector (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // board pins, asynchronous
  input wire logic test_reset,
  input wire logic [1:0] strap_pins,
  // one-time-programmable content, same clock
  input wire logic strap_override_en,
  input wire logic [1:0] strap_override,
  input wire logic [31:0] zone_one_word,
  input wire logic [31:0] zone_two_word,
  // boot decision
  output logic boot_done,
  output logic [2:0] boot_mode,
  output logic pin_option,
  output logic xtal_select,
  output logic app_release,
  // axi4-lite write address
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic [2:0] sync_c;
  logic pins_agree;
  logic [3:0] settle_cnt;

  // three stages for test reset and both straps
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
      sync_c <= 3'h0;
    end else begin
      sync_a <= {test_reset, strap_pins};
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  assign pins_agree = (sync_b == sync_c);

  // settle on agreement
  // pins must sit still, undriven, until the settle count runs out
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settle_cnt <= 4'h0;
    end else if (!pins_agree) begin
      settle_cnt <= 4'h0;
    end else if (settle_cnt != `SETTLE_CYCLES) begin
      settle_cnt <= settle_cnt + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // control word decoding
  // ----------------------------------------------------------------
  logic emu_wr;
  logic [31:0] emu_word;
  boot_sel_pkg::sel_state_t state;
  boot_sel_pkg::boot_sel_t sel;
  logic emu_seen;
  logic [1:0] strap_mode;

  // key must match; the code field is not checked
  function automatic logic word_valid(input logic [31:0] w);
    word_valid = (w[`KEY_MSB:`KEY_LSB] == `KEY_VALUE);
  endfunction

  // zone words may only steer get boot to flash or a peripheral loader
  function automatic logic zone_valid(input logic [31:0] w);
    logic [2:0] c;
    c = w[`CODE_MSB:`CODE_LSB];
    zone_valid = word_valid(w) && (c >= boot_sel_pkg::MODE_FLASH);
  endfunction

  // programmed straps
  // otp values stand in for the factory pins when enabled
  assign strap_mode = strap_override_en ? strap_override : sync_c[1:0];

  // ----------------------------------------------------------------
  // selection sequence
  // ----------------------------------------------------------------
  // sequence on reset exit
  // runs once from reset; only a write retargeting an emulation wait changes outputs before the next reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= boot_sel_pkg::ST_SETTLE;
      sel <= '{boot_sel_pkg::MODE_WAIT, 1'b0, boot_sel_pkg::SRC_STRAP};
      emu_seen <= 1'b0;
    end else begin
      case (state)
        boot_sel_pkg::ST_SETTLE: begin
          if (settle_cnt == `SETTLE_CYCLES) begin
            state <= boot_sel_pkg::ST_STRAP;
          end
        end
        boot_sel_pkg::ST_STRAP: begin
          // single sample
          // pin levels taken here only, later changes are ignored
          emu_seen <= sync_c[2];
          if (sync_c[2]) begin
            state <= boot_sel_pkg::ST_EMU;
          end else begin
            case (strap_mode)
              2'h0: begin
                sel.mode <= boot_sel_pkg::MODE_PARALLEL;
                state <= boot_sel_pkg::ST_DONE;
              end
              2'h1: begin
                sel.mode <= boot_sel_pkg::MODE_SERIAL;
                sel.pin_option <= 1'b0;
                state <= boot_sel_pkg::ST_DONE;
              end
              2'h2: begin
                sel.mode <= boot_sel_pkg::MODE_WAIT;
                state <= boot_sel_pkg::ST_DONE;
              end
              default: begin
                state <= boot_sel_pkg::ST_ZONE_ONE;
              end
            endcase
          end
        end
        boot_sel_pkg::ST_ZONE_ONE: begin
          if (zone_valid(zone_one_word)) begin
            sel.mode <= boot_sel_pkg::boot_mode_t'(
              zone_one_word[`CODE_MSB:`CODE_LSB]);
            sel.pin_option <= zone_one_word[`OPTION_BIT];
            sel.source <= boot_sel_pkg::SRC_ZONE_ONE;
            state <= boot_sel_pkg::ST_DONE;
          end else begin
            state <= boot_sel_pkg::ST_ZONE_TWO;
          end
        end
        boot_sel_pkg::ST_ZONE_TWO: begin
          if (zone_valid(zone_two_word)) begin
            sel.mode <= boot_sel_pkg::boot_mode_t'(
              zone_two_word[`CODE_MSB:`CODE_LSB]);
            sel.pin_option <= zone_two_word[`OPTION_BIT];
            sel.source <= boot_sel_pkg::SRC_ZONE_TWO;
          end else begin
            sel.mode <= boot_sel_pkg::MODE_FLASH;
            sel.pin_option <= 1'b0;
          end
          state <= boot_sel_pkg::ST_DONE;
        end
        boot_sel_pkg::ST_EMU: begin
          sel.source <= boot_sel_pkg::SRC_EMU;
          if (word_valid(emu_word)) begin
            sel.mode <= boot_sel_pkg::boot_mode_t'(
              emu_word[`CODE_MSB:`CODE_LSB]);
            sel.pin_option <= emu_word[`OPTION_BIT];
          end else begin
            sel.mode <= boot_sel_pkg::MODE_WAIT;
            sel.pin_option <= 1'b0;
          end
          state <= boot_sel_pkg::ST_DONE;
        end
        boot_sel_pkg::ST_DONE: begin
          // debugger may retarget an emulation wait by a fresh write
          if (emu_seen && emu_wr &&
              sel.mode == boot_sel_pkg::MODE_WAIT) begin
            state <= boot_sel_pkg::ST_EMU;
          end
        end
        default: begin
          state <= boot_sel_pkg::ST_SETTLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // decision outputs
  // ----------------------------------------------------------------
  // registered copies of the final decision
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boot_done <= 1'b0;
      boot_mode <= boot_sel_pkg::MODE_WAIT;
      pin_option <= 1'b0;
      xtal_select <= 1'b0;
      app_release <= 1'b0;
    end else begin
      boot_done <= (state == boot_sel_pkg::ST_DONE);
      boot_mode <= sel.mode;
      pin_option <= sel.pin_option;
      xtal_select <= (state == boot_sel_pkg::ST_DONE) &&
        (sel.mode == boot_sel_pkg::MODE_USB);
      app_release <= (state == boot_sel_pkg::ST_DONE) &&
        (sel.mode != boot_sel_pkg::MODE_WAIT);
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite write path
  // ----------------------------------------------------------------
  logic aw_held;
  logic w_held;
  logic [31:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [31:0] next_emu_word;
  logic emu_wr_go;

  // take address and data in either order, one write at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 32'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (emu_wr_go) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (emu_wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  logic wr_hit;
  assign emu_wr_go = aw_held && w_held && !s_axi_bvalid;
  assign wr_hit = (aw_addr & `ADDR_WORD_MASK) == `OFS_EMU_WORD;
  assign emu_wr = emu_wr_go && wr_hit;

  // byte lanes merged into the emulation word
  always_comb begin
    next_emu_word = emu_word;
    for (int i = 0; i < 4; i++) begin
      if (w_strb[i]) begin
        next_emu_word[i*8 +: 8] = w_data[i*8 +: 8];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      emu_word <= `EMU_WORD_RESET;
    end else if (emu_wr) begin
      emu_word <= next_emu_word;
    end
  end

  // write response, status words are read only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else if (emu_wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read path
  // ----------------------------------------------------------------
  logic [31:0] status_word;

  // decision summary for software
  always_comb begin
    status_word = 32'h0;
    status_word[`ST_DONE_BIT] = boot_done;
    status_word[`ST_EMU_BIT] = emu_seen;
    status_word[`ST_OPT_BIT] = pin_option;
    status_word[`ST_MODE_MSB:`ST_MODE_LSB] = boot_mode;
    status_word[`ST_SRC_MSB:`ST_SRC_LSB] = sel.source;
    status_word[`ST_XTAL_BIT] = xtal_select;
  end

  // one read at a time, answer one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        if ((s_axi_araddr & `ADDR_WORD_MASK) == `OFS_EMU_WORD) begin
          s_axi_rdata <= emu_word;
        end else if ((s_axi_araddr & `ADDR_WORD_MASK) == `OFS_STATUS) begin
          s_axi_rdata <= status_word;
        end else if ((s_axi_araddr & `ADDR_WORD_MASK) ==
                     `OFS_ZONE_ONE) begin
          s_axi_rdata <= zone_one_word;
        end else if ((s_axi_araddr & `ADDR_WORD_MASK) ==
                     `OFS_ZONE_TWO) begin
          s_axi_rdata <= zone_two_word;
        end else begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= `RESP_SLVERR;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// [sim/boot_mode_selector_sva.sv]
// assertions on the boot mode selector ports
`timescale 1ns/1ps
`default_nettype none

module boot_mode_selector_sva (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // boot decision
  input wire logic boot_done,
  input wire logic [2:0] boot_mode,
  input wire logic xtal_select,
  input wire logic app_release,
  // register port handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // single clock domain
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ------
  // steps
  // ------
  // first edge out of reset
  sequence released;
    $rose(aresetn);
  endsequence
  // a final decision that no write may redo
  sequence decided;
    boot_done && boot_mode != 3'h2;
  endsequence
  // write address taken
  sequence aw_taken;
    s_axi_awvalid && s_axi_awready;
  endsequence

  // ------
  // checks
  // ------
  a_done_bound:
    assert property (released |-> !boot_done ##[4:16] boot_done)
    else $error("boot decision not made in time");
  a_quiet_start:
    assert property (released |-> !app_release && !xtal_select
      && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active at reset exit");
  a_wait_holds:
    assert property (app_release == (boot_done && boot_mode != 3'h2))
    else $error("application release wrong");
  a_usb_crystal:
    assert property (xtal_select == (boot_done && boot_mode == 3'h7))
    else $error("crystal select wrong");
  a_mode_hold:
    assert property (decided |=> boot_done && $stable(boot_mode))
    else $error("boot decision changed");
  a_write_answer:
    assert property (aw_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read data missing");
  a_bresp_stands:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_rdata_stands:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped");
  a_read_refused:
    assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
endmodule

bind boot_mode_selector boot_mode_selector_sva boot_mode_selector_sva_i (
  .aclk, .aresetn, .boot_done, .boot_mode, .xtal_select, .app_release,
  .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready);

`default_nettype wire

// [sim/boot_mode_selector_test.sv]
// self-checking bench for the boot mode selector
`timescale 1ns/1ps
`default_nettype none
`include "boot_sel_map.svh"

module boot_mode_selector_test;
  logic aclk, aresetn, probe_on, test_reset, strap_override_en, boot_done;
  logic pin_option, xtal_select, app_release, s_axi_awvalid, s_axi_awready;
  logic s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] strap_level, strap_pins, strap_override, s_axi_bresp;
  logic [1:0] s_axi_rresp;
  logic [2:0] boot_mode;
  logic [3:0] s_axi_wstrb, exp_sel;
  logic [31:0] zone_one_word, zone_two_word, s_axi_awaddr, s_axi_wdata;
  logic [31:0] s_axi_araddr, s_axi_rdata;
  int mismatches, checks;

  // board and device
  boot_pins_model boot_pins_model_i (.probe_on, .strap_level, .test_reset,
    .strap_pins);
  boot_mode_selector boot_mode_selector_i (.aclk, .aresetn, .test_reset,
    .strap_pins, .strap_override_en, .strap_override, .zone_one_word,
    .zone_two_word, .boot_done, .boot_mode, .pin_option, .xtal_select,
    .app_release, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  // 40 MHz clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // ---------
  // helpers
  // ---------
  // counts, verdict and stop
  task automatic end_sim();
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // one comparison
  task automatic check(input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  // decision outputs against an expected option and mode
  task automatic verify(input logic [3:0] e);
    check({26'h0, e[2:0] == 3'h7, e[2:0] != 3'h2, e},
      {26'h0, xtal_select, app_release, pin_option, boot_mode});
  endtask

  // zone word usable: key present, flash or a loader
  function automatic logic zv(input logic [31:0] w);
    return w[7:0] == `KEY_VALUE && w[10:8] >= 3'h3;
  endfunction

  // expected option and mode from pins and zone words
  function automatic logic [3:0] pick(input logic pr, input logic [1:0] s,
      input logic [31:0] z1, input logic [31:0] z2);
    if (pr) return {1'b0, boot_sel_pkg::MODE_WAIT};
    if (s != 2'h3) return {2'h0, s};
    if (zv(z1)) return {z1[12], z1[10:8]};
    if (zv(z2)) return {z2[12], z2[10:8]};
    return {1'b0, boot_sel_pkg::MODE_FLASH};
  endfunction

  // random word, key present half the time
  function automatic logic [31:0] rw();
    logic [31:0] w;
    w = $urandom;
    if (w[31]) w[7:0] = `KEY_VALUE;
    return w;
  endfunction

  // wait for a given decision, bounded
  task automatic wait_done(input logic [3:0] e);
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (n < 40 && {boot_done, pin_option, boot_mode} !== {1'b1, e});
    verify(e);
    if (n >= 40) end_sim();
  endtask

  // reset with new pins and words, then await the decision
  task automatic boot(input logic pr, input logic [1:0] st, input logic oe,
      input logic [1:0] ov, input logic [31:0] z1, input logic [31:0] z2);
    @(posedge aclk);
    {aresetn, probe_on, strap_level, strap_override_en} <= {1'b0, pr, st, oe};
    {strap_override, zone_one_word, zone_two_word} <= {ov, z1, z2};
    exp_sel = pick(pr, oe ? ov : st, z1, z2);
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    wait_done(exp_sel);
  endtask

  // one bus transfer, a write when wr is set
  task automatic axi(input logic wr, input logic [31:0] a,
      input logic [31:0] dat, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    if (wr) begin
      {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, dat, 4'hf};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    end else begin
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    end
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (n < 40 && (wr ? s_axi_bvalid : s_axi_rvalid) !== 1'b1);
    {d, r} = wr ? {32'h0, s_axi_bresp} : {s_axi_rdata, s_axi_rresp};
    {s_axi_bready, s_axi_rready} <= 2'h0;
    @(posedge aclk);
    if (n >= 40) begin
      mismatches++;
      end_sim();
    end
  endtask

  // ---------
  // scenarios
  // ---------
  initial begin
    logic [31:0] w, d;
    logic [1:0] r;
    {aresetn, probe_on, strap_override_en, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, strap_level} = '0;
    {strap_override, s_axi_wstrb, s_axi_awaddr, s_axi_wdata} = '0;
    {s_axi_araddr, zone_one_word, zone_two_word, mismatches, checks} = '0;
    void'($urandom(54));
    for (int i = 0; i < 4; i++) begin
      boot(1'b0, i[1:0], 1'b0, 2'h0, '1, '1);
      strap_level <= ~strap_level;
      repeat (8) @(posedge aclk);
      verify(exp_sel);
    end
    for (int c = 3; c < 8; c++) begin
      w = {19'h0, c[0], 1'b0, c[2:0], `KEY_VALUE};
      boot(1'b0, 2'h3, 1'b0, 2'h0, w, '1);
    end
    boot(1'b0, 2'h3, 1'b0, 2'h0, '1, {19'h0, 2'h2, 3'h6, `KEY_VALUE});
    repeat (8) boot(1'b0, 2'h3, 1'b0, 2'h0, rw(), rw());
    boot(1'b0, 2'h3, 1'b1, 2'h1, '1, '1);
    boot(1'b0, 2'h0, 1'b1, 2'h3, '1, '1);
    boot(1'b1, 2'($urandom), 1'b0, 2'h0, rw(), rw());
    axi(1'b0, `OFS_EMU_WORD, 32'h0, d, r);
    check(`EMU_WORD_RESET, d);
    axi(1'b1, `OFS_EMU_WORD, 32'h0000_07a5, d, r);
    check({30'h0, `RESP_OKAY}, {30'h0, r});
    repeat (8) @(posedge aclk);
    verify(4'h2);
    w = {19'h0, 2'h2, 3'h7, `KEY_VALUE};
    axi(1'b1, `OFS_EMU_WORD, w, d, r);
    wait_done(4'hf);
    axi(1'b0, `OFS_STATUS, 32'h0, d, r);
    check(32'h0000_0577, d);
    axi(1'b0, `OFS_EMU_WORD, 32'h0, d, r);
    check(w, d);
    axi(1'b1, `OFS_EMU_WORD, 32'h0, d, r);
    repeat (8) @(posedge aclk);
    verify(4'hf);
    axi(1'b1, `OFS_ZONE_ONE, 32'h0, d, r);
    check({30'h0, `RESP_SLVERR}, {30'h0, r});
    axi(1'b0, `OFS_ZONE_TWO, 32'h0, d, r);
    check(zone_two_word, d);
    axi(1'b0, 32'h0000_0010, 32'h0, d, r);
    check({30'h0, `RESP_SLVERR}, {30'h0, r});
    check(32'h0, d);
    end_sim();
  end
endmodule

`default_nettype wire

// [sim/boot_pins_model.sv]
// board side model: debug probe and boot strap pins
`timescale 1ns/1ps
`default_nettype none

module boot_pins_model (
  // bench control
  input wire logic probe_on,
  input wire logic [1:0] strap_level,
  // pins toward the device
  output logic test_reset,
  output logic [1:0] strap_pins
);
  assign test_reset = probe_on;
  assign strap_pins = strap_level;
endmodule

`default_nettype wire
